//--- common/motion_io_action_pkg.sv
// Types shared by the I/O action block
package motion_io_action_pkg;
   // Stop sequencer, Gray coded along idle-decel-halted
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_DECEL  = 2'b01,
      ST_HALTED = 2'b11
   } stop_state_t;
   // Limit selector codes, -1 stored as all ones
   typedef enum logic [2:0]
   {
      LIM_HOME  = 3'h7,
      LIM_IMM   = 3'h0,
      LIM_DEC   = 3'h1,
      LIM_IMM_A = 3'h2,
      LIM_DEC_A = 3'h3
   } limit_act_t;
   // Interrupt event bit positions
   typedef enum int
   {
      EV_ALARM = 0,
      EV_HOME  = 1,
      EV_IMM   = 2,
      EV_DEC   = 3
   } event_t;
endpackage

//--- common/motion_io_action_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MOTION_IO_ACTION_REGS_SVH
`define MOTION_IO_ACTION_REGS_SVH
`define A_CTRL      8'h00
`define A_INPOS     8'h04
`define A_LEARN     8'h08
`define A_ZSG       8'h0C
`define A_RND       8'h10
`define A_MOVE      8'h14
`define A_PLS       8'h18
`define A_CRNT      8'h1C
`define A_SPDR      8'h20
`define A_SPDV      8'h24
`define A_IST       8'h28
`define A_ICLR      8'h2C
`define A_IEN       8'h30
`define A_STATE     8'h34
`define A_ALMCLR    8'h38
`define F_HALT      1:0
`define F_LIMIT     4:2
`define F_BLOCK     5
`define F_DSEL      6
`define F_PAUSE     7
`define F_RSRC      8
`define F_SMETH     9
`define RST_CTRL    10'h06B
`define RST_RANGE   8'h12
`define RST_OFFSET  8'h00
`define RST_LEARN   8'h01
`define RST_ZSG     11'h012
`define RST_RND     14'h000A
`define RST_MOVE    8'h00
`define RST_PLS     5'h0A
`define RST_CRNT    10'h1F4
`define RST_SPDR    7'h32
`define RST_SPDV    22'h0003E8
`define MAX_RANGE   8'hB4
`define MAX_OFFSET  8'h12
`define MAX_ZSG     11'h708
`define MAX_RND     14'h2710
`define MIN_PLS     5'h02
`define MAX_PLS     5'h1E
`define MAX_CRNT    10'h3E8
`define MAX_SPDR    7'h64
`define MAX_SPDV    22'h3D0900
`define CLK_MHZ     250
`define MS_TIME     1
`define MS_CYCLES   (`MS_TIME * `CLK_MHZ * 1000)
`endif

//--- core/motion_io_action_config.sv
// I/O action and window logic for the closed-loop motor driver
`include "motion_io_action_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module motion_io_action_config
#(
   parameter int MS_CYCLES = `MS_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             irq,
   input  wire logic        halt_input,
   input  wire logic        halt_current_off_input,
   input  wire logic        forward_limit_sensor_input,
   input  wire logic        reverse_limit_sensor_input,
   input  wire logic        forward_block_input,
   input  wire logic        reverse_block_input,
   input  wire logic        pause_input,
   input  wire logic        direct_select_input,
   input  wire logic        learn_strobe,
   input  wire logic        pulse_multiply_input,
   input  wire logic        current_limit_input,
   input  wire logic        speed_limit_input,
   input  wire logic        core_moving,
   input  wire logic [15:0] pos_err,
   input  wire logic [11:0] elec_angle,
   input  wire logic [13:0] fb_wrap_pos,
   input  wire logic [13:0] cmd_wrap_pos,
   output logic             stop_immediate,
   output logic             stop_decel,
   output logic             current_off,
   output logic             standstill,
   output logic             motion_enable,
   output logic             alarm,
   output logic             home_sensor_event,
   output logic             op_select,
   output logic             op_start,
   output logic             learn_type_we,
   output logic      [7:0]  learn_type,
   output logic             in_position,
   output logic             zero_phase_status_output,
   output logic             wrap_zero_output,
   output logic             move_out,
   output logic             current_cutback,
   output logic             current_hold,
   output logic      [4:0]  pulse_factor,
   output logic      [9:0]  current_ratio,
   output logic             speed_limit_active,
   output logic             speed_limit_mode,
   output logic      [6:0]  speed_limit_ratio,
   output logic      [21:0] speed_limit_hz
);
   // Elaboration check on the millisecond count
   if (MS_CYCLES < 1)
   begin : g_bad
      $error("MS_CYCLES must be at least one");
   end

   logic [9:0]  ctrl_q;        // Selector word
   logic [7:0]  range_q;       // In-position range
   logic [7:0]  offset_q;      // In-position offset, signed
   logic [7:0]  learn_q;       // Learn type, signed
   logic [10:0] zsg_q;         // Zero-phase width
   logic [13:0] rnd_q;         // Wrap-zero width
   logic [7:0]  move_q;        // Moving minimum, ms
   logic [4:0]  pls_q;         // Multiply factor
   logic [9:0]  crnt_q;        // Current limit ratio
   logic [6:0]  spdr_q;        // Speed ratio
   logic [21:0] spdv_q;        // Speed value
   logic [3:0]  ist_q;         // Sticky events
   logic [3:0]  ien_q;         // Event enables
   logic [3:0]  ev;            // Event pulses
   logic        alarm_q;       // Latched limit alarm
   logic        dsel_q;        // Direct select history
   logic [31:0] ms_cnt_q;      // Cycles within one ms
   logic [7:0]  move_ms_q;     // Elapsed ms of moving
   motion_io_action_pkg::stop_state_t st_q;

   // Signed range check for values written by software
   function automatic logic in_span(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
      in_span = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction

   // Decoded write strobe for one offset
   function automatic logic wr_at(input logic [7:0] a);
      wr_at = wr && (addr == a);
   endfunction

   // Parameter registers; out-of-span writes are ignored
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl_q   <= `RST_CTRL;
         range_q  <= `RST_RANGE;
         offset_q <= `RST_OFFSET;
         learn_q  <= `RST_LEARN;
         zsg_q    <= `RST_ZSG;
         rnd_q    <= `RST_RND;
         move_q   <= `RST_MOVE;
         pls_q    <= `RST_PLS;
         crnt_q   <= `RST_CRNT;
         spdr_q   <= `RST_SPDR;
         spdv_q   <= `RST_SPDV;
         ien_q    <= 4'h0;
      end
      else if (wr_at(`A_CTRL))
      begin
         // Limit code 4..6 is not a legal selector
         if (!(wdata[4] && wdata[3:2] != 2'h3))
            ctrl_q <= wdata[9:0];
      end
      else if (wr_at(`A_INPOS))
      begin
         if (wdata[7:0] <= `MAX_RANGE)
            range_q <= wdata[7:0];
         if (in_span({{24{wdata[15]}}, wdata[15:8]}, -32'sd18, 32'sd18))
            offset_q <= wdata[15:8];
      end
      else if (wr_at(`A_LEARN))
      begin
         // Only keep, absolute and wrap absolute
         if (wdata[7:0] == 8'hFF || wdata[7:0] == 8'h01 || wdata[7:0] == 8'h08)
            learn_q <= wdata[7:0];
      end
      else if (wr_at(`A_ZSG))
      begin
         if (in_span(wdata, 32'h1, {21'h0, `MAX_ZSG}))
            zsg_q <= wdata[10:0];
      end
      else if (wr_at(`A_RND))
      begin
         if (in_span(wdata, 32'h1, {18'h0, `MAX_RND}))
            rnd_q <= wdata[13:0];
      end
      else if (wr_at(`A_MOVE))
         move_q <= wdata[7:0];
      else if (wr_at(`A_PLS))
      begin
         if (in_span(wdata, {27'h0, `MIN_PLS}, {27'h0, `MAX_PLS}))
            pls_q <= wdata[4:0];
      end
      else if (wr_at(`A_CRNT))
      begin
         if (in_span(wdata, 32'h0, {22'h0, `MAX_CRNT}))
            crnt_q <= wdata[9:0];
      end
      else if (wr_at(`A_SPDR))
      begin
         if (in_span(wdata, 32'h1, {25'h0, `MAX_SPDR}))
            spdr_q <= wdata[6:0];
      end
      else if (wr_at(`A_SPDV))
      begin
         if (in_span(wdata, 32'h1, {10'h0, `MAX_SPDV}))
            spdv_q <= wdata[21:0];
      end
      else if (wr_at(`A_IEN))
         ien_q <= wdata[3:0];
   end

   // Stop request decode from the selectors
   logic lim_any;   // Either limit sensor
   logic blk_any;   // Either block input
   logic lim_stop;  // Limit acts as a stop
   logic lim_alm;   // Limit stop raises alarm
   logic req_imm;   // Some immediate stop wanted
   logic req_dec;   // Some decel stop wanted
   logic [2:0] lim_act;
   always_comb
   begin
      lim_act  = ctrl_q[`F_LIMIT];
      lim_any  = forward_limit_sensor_input | reverse_limit_sensor_input;
      blk_any  = forward_block_input | reverse_block_input;
      lim_stop = lim_any && (lim_act != motion_io_action_pkg::LIM_HOME);
      lim_alm  = lim_stop && lim_act[1];
      // Halt decel on bit 0, current-off decel on bit 1
      req_imm  = (halt_input && !ctrl_q[0])
               || (halt_current_off_input && !ctrl_q[1])
               || (lim_stop && !lim_act[0])
               || (blk_any && !ctrl_q[`F_BLOCK])
               || alarm_q;
      req_dec  = (halt_input && ctrl_q[0])
               || (halt_current_off_input && ctrl_q[1])
               || (lim_stop && lim_act[0])
               || (blk_any && ctrl_q[`F_BLOCK]);
   end

   // Stop sequencer; immediate beats deceleration
   always_ff @(posedge core_clk)
   begin
      if (rst)
         st_q <= motion_io_action_pkg::ST_IDLE;
      else
      begin
         case (st_q)
            motion_io_action_pkg::ST_IDLE:
            begin
               if (req_imm)
                  st_q <= motion_io_action_pkg::ST_HALTED;
               else if (req_dec)
                  st_q <= motion_io_action_pkg::ST_DECEL;
            end
            motion_io_action_pkg::ST_DECEL:
            begin
               // Core ramps down; wait for it to stop
               if (req_imm || !core_moving)
                  st_q <= motion_io_action_pkg::ST_HALTED;
            end
            default:
            begin
               if (!req_imm && !req_dec)
                  st_q <= motion_io_action_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Stop outputs from flops, one cycle after the cause
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         stop_immediate <= 1'b0;
         stop_decel     <= 1'b0;
         current_off    <= 1'b0;
      end
      else
      begin
         stop_immediate <= req_imm;
         stop_decel     <= req_dec && !req_imm;
         current_off    <= halt_current_off_input;
      end
   end

   assign standstill    = (st_q == motion_io_action_pkg::ST_HALTED);
   assign motion_enable = (st_q == motion_io_action_pkg::ST_IDLE) && !alarm_q;
   assign alarm         = alarm_q;

   // Alarm latch; a new limit hit wins over the clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
         alarm_q <= 1'b0;
      else if (lim_alm)
         alarm_q <= 1'b1;
      else if (wr_at(`A_ALMCLR) && wdata[0])
         alarm_q <= 1'b0;
   end

   // Home sensor mode passes the limit as a home event
   always_ff @(posedge core_clk)
   begin
      if (rst)
         home_sensor_event <= 1'b0;
      else
         home_sensor_event <= lim_any && (lim_act == motion_io_action_pkg::LIM_HOME);
   end

   // Direct select: rising edge selects, optionally starts
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         dsel_q    <= 1'b0;
         op_select <= 1'b0;
         op_start  <= 1'b0;
      end
      else
      begin
         dsel_q    <= direct_select_input;
         op_select <= direct_select_input && !dsel_q;
         op_start  <= direct_select_input && !dsel_q && ctrl_q[`F_DSEL] && !alarm_q;
      end
   end

   // Learn: store operation type unless set to keep
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         learn_type_we <= 1'b0;
         learn_type    <= `RST_LEARN;
      end
      else
      begin
         learn_type_we <= learn_strobe && (learn_q != 8'hFF);
         learn_type    <= learn_q;
      end
   end

   // Window outputs: in-position, zero phase, wrap zero
   logic signed [16:0] err_sh;   // Error minus offset
   logic        [16:0] err_abs;  // Its magnitude
   logic        [13:0] wrap_pos; // Selected wrap position
   always_comb
   begin
      err_sh   = $signed({pos_err[15], pos_err}) - $signed({{9{offset_q[7]}}, offset_q});
      err_abs  = err_sh[16] ? 17'(-err_sh) : 17'(err_sh);
      wrap_pos = ctrl_q[`F_RSRC] ? cmd_wrap_pos : fb_wrap_pos;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         in_position              <= 1'b0;
         zero_phase_status_output <= 1'b0;
         wrap_zero_output         <= 1'b0;
      end
      else
      begin
         in_position              <= err_abs <= {9'h0, range_q};
         zero_phase_status_output <= {1'b0, elec_angle} < {1'b0, zsg_q, 1'b0} >> 1;
         wrap_zero_output         <= wrap_pos < rnd_q;
      end
   end

   // Minimum still pending; runs whether or not the core moves
   logic move_run;
   assign move_run = move_out && (move_ms_q < move_q);

   // Moving output held for the minimum ms count
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         move_out  <= 1'b0;
         ms_cnt_q  <= 32'h0;
         move_ms_q <= 8'h0;
      end
      else if (core_moving && !move_out)
      begin
         // Fresh rise restarts the minimum
         move_out  <= 1'b1;
         ms_cnt_q  <= 32'h0;
         move_ms_q <= 8'h0;
      end
      else if (move_run)
      begin
         // Counts from the rising edge of the output
         if (ms_cnt_q == 32'(MS_CYCLES - 1))
         begin
            ms_cnt_q  <= 32'h0;
            move_ms_q <= move_ms_q + 8'h1;
         end
         else
            ms_cnt_q <= ms_cnt_q + 32'h1;
      end
      else if (!core_moving)
         move_out <= 1'b0;
   end

   // Current, pulse and speed limit outputs
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         current_cutback    <= 1'b0;
         current_hold       <= 1'b0;
         pulse_factor       <= 5'h01;
         current_ratio      <= `MAX_CRNT;
         speed_limit_active <= 1'b0;
         speed_limit_mode   <= 1'b0;
         speed_limit_ratio  <= `RST_SPDR;
         speed_limit_hz     <= `RST_SPDV;
      end
      else
      begin
         current_cutback    <= pause_input && !ctrl_q[`F_PAUSE];
         current_hold       <= pause_input && ctrl_q[`F_PAUSE];
         pulse_factor       <= pulse_multiply_input ? pls_q : 5'h01;
         current_ratio      <= current_limit_input ? crnt_q : `MAX_CRNT;
         speed_limit_active <= speed_limit_input;
         speed_limit_mode   <= ctrl_q[`F_SMETH];
         speed_limit_ratio  <= spdr_q;
         speed_limit_hz     <= spdv_q;
      end
   end

   // Sticky events; a new event beats the clear
   assign ev = {req_dec && !req_imm && !stop_decel,
                req_imm && !stop_immediate,
                lim_any && (lim_act == motion_io_action_pkg::LIM_HOME) && !home_sensor_event,
                lim_alm && !alarm_q};
   always_ff @(posedge core_clk)
   begin
      if (rst)
         ist_q <= 4'h0;
      else
         ist_q <= ev | (ist_q & ~(wr_at(`A_ICLR) ? wdata[3:0] : 4'h0));
   end
   assign irq = |(ist_q & ien_q);

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk)
   begin
      if (rst || !rd)
         rdata <= 32'h0;
      else if (addr == `A_CTRL)
         rdata <= {22'h0, ctrl_q};
      else if (addr == `A_INPOS)
         rdata <= {16'h0, offset_q, range_q};
      else if (addr == `A_LEARN)
         rdata <= {24'h0, learn_q};
      else if (addr == `A_ZSG)
         rdata <= {21'h0, zsg_q};
      else if (addr == `A_RND)
         rdata <= {18'h0, rnd_q};
      else if (addr == `A_MOVE)
         rdata <= {24'h0, move_q};
      else if (addr == `A_PLS)
         rdata <= {27'h0, pls_q};
      else if (addr == `A_CRNT)
         rdata <= {22'h0, crnt_q};
      else if (addr == `A_SPDR)
         rdata <= {25'h0, spdr_q};
      else if (addr == `A_SPDV)
         rdata <= {10'h0, spdv_q};
      else if (addr == `A_IST)
         rdata <= {28'h0, ist_q};
      else if (addr == `A_IEN)
         rdata <= {28'h0, ien_q};
      else if (addr == `A_STATE)
         rdata <= {24'h0, move_out, wrap_zero_output, zero_phase_status_output,
                   in_position, alarm_q, 1'b0, st_q};
      else
         rdata <= 32'h0;
   end

   // Assertions
   sequence halt_seen_s;
      halt_input && !ctrl_q[0];
   endsequence
   sequence imm_out_s;
      stop_immediate;
   endsequence

   halt_imm_a: assert property (@(posedge core_clk) disable iff (rst)
      halt_seen_s |=> imm_out_s)
      else $error("immediate halt not issued");
   limit_home_a: assert property (@(posedge core_clk) disable iff (rst)
      lim_any && lim_act == motion_io_action_pkg::LIM_HOME && !req_imm && !req_dec
      |=> !stop_immediate && !stop_decel && home_sensor_event)
      else $error("home mode limit stopped motor");
   block_dec_a: assert property (@(posedge core_clk) disable iff (rst)
      blk_any && ctrl_q[`F_BLOCK] && !req_imm |=> stop_decel)
      else $error("block decel missing");
   inpos_win_a: assert property (@(posedge core_clk) disable iff (rst)
      $past(!rst) |-> in_position == ($past(err_abs) <= {9'h0, $past(range_q)}))
      else $error("in-position window wrong");
   dsel_start_a: assert property (@(posedge core_clk) disable iff (rst)
      op_start |-> op_select && !$past(dsel_q) && $past(ctrl_q[`F_DSEL]))
      else $error("start without select");
   wrap_src_a: assert property (@(posedge core_clk) disable iff (rst)
      ctrl_q[`F_RSRC] && $stable(ctrl_q) |=> wrap_zero_output == ($past(cmd_wrap_pos) < $past(rnd_q)))
      else $error("wrap zero source wrong");
   move_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(move_out) |-> $past(move_ms_q) >= $past(move_q))
      else $error("moving dropped early");
   pause_cur_a: assert property (@(posedge core_clk) disable iff (rst)
      pause_input |=> current_cutback != current_hold)
      else $error("pause current mode wrong");
   alarm_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      alarm_q && !(wr_at(`A_ALMCLR) && wdata[0]) |=> alarm_q && !motion_enable)
      else $error("alarm lost or motion allowed");
   crnt_lim_a: assert property (@(posedge core_clk) disable iff (rst)
      current_limit_input |=> current_ratio == $past(crnt_q))
      else $error("current limit not applied");
endmodule
`default_nettype wire

//--- dv/motion_core_model.sv
// Behavioural motion core that ramps down on a decelerating stop
`timescale 1ns/1ps
`default_nettype none
module motion_core_model
#(
   parameter int DEC_CYCLES = 6
)
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic stop_immediate,
   input  wire logic stop_decel,
   output logic      core_moving
);
   // Ramp cycles left; zero is standstill
   logic [7:0] ramp_q;
   // Immediate stop drops motion at once; a slow ramp exposes early standstill
   always_ff @(posedge core_clk)
   begin
      if (rst || stop_immediate)
         ramp_q <= 8'h00;
      else if (stop_decel)
      begin
         // Count the ramp down, then stay put
         if (ramp_q != 8'h00)
            ramp_q <= ramp_q - 8'h01;
      end
      else if (run)
         ramp_q <= 8'(DEC_CYCLES);
      else
         ramp_q <= 8'h00;
   end
   assign core_moving = (ramp_q != 8'h00);
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the I/O action block
`timescale 1ns/1ps
`default_nettype none
`include "motion_io_action_regs.svh"
module testbench;
   // One stop case: control word, inputs, expected {home,alarm,decel,imm}, mask
   typedef struct packed {logic [9:0] ctrl; logic [5:0] vin; logic [3:0] ex; logic [3:0] m;} row_t;
   logic core_clk = 0, rst = 1, wr = 0, rd = 0, run = 0, pause_input = 0;
   logic direct_select_input = 0, learn_strobe = 0, pulse_multiply_input = 0;
   logic current_limit_input = 0, speed_limit_input = 0;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [5:0] vin = 0; // {reverse_limit_sensor_input, forward_limit_sensor_input, reverse_block_input, forward_block_input, current off, halt}
   logic [15:0] pos_err = 0;
   logic [11:0] elec_angle = 0;
   logic [13:0] fb_wrap_pos = 0, cmd_wrap_pos = 0;
   wire halt_input = vin[0], halt_current_off_input = vin[1];
   wire forward_block_input = vin[2], reverse_block_input = vin[3];
   wire forward_limit_sensor_input = vin[4], reverse_limit_sensor_input = vin[5];
   logic irq, core_moving, stop_immediate, stop_decel, current_off, standstill;
   logic motion_enable, alarm, home_sensor_event, op_select, op_start, learn_type_we;
   logic in_position, zero_phase_status_output, wrap_zero_output, move_out;
   logic current_cutback, current_hold, speed_limit_active, speed_limit_mode;
   logic [7:0] learn_type;
   logic [4:0] pulse_factor;
   logic [9:0] current_ratio;
   logic [6:0] speed_limit_ratio;
   logic [21:0] speed_limit_hz;
   int n_mismatch = 0, n_compared = 0, n;
   // Stop table: halt codes on both halt inputs, block codes, limit codes
   row_t rows [15] = '{'{10'h068,6'h01,4'h1,4'hF}, '{10'h069,6'h01,4'h2,4'hF},
      '{10'h06A,6'h01,4'h1,4'hF}, '{10'h06B,6'h01,4'h2,4'hF}, '{10'h068,6'h02,4'h1,4'hF},
      '{10'h069,6'h02,4'h1,4'hF}, '{10'h06A,6'h02,4'h2,4'hF}, '{10'h06B,6'h02,4'h2,4'hF},
      '{10'h04B,6'h04,4'h1,4'hF}, '{10'h06B,6'h08,4'h2,4'hF}, '{10'h07F,6'h10,4'h8,4'hF},
      '{10'h063,6'h20,4'h1,4'hF}, '{10'h067,6'h10,4'h2,4'hF}, '{10'h06B,6'h20,4'h5,4'hF},
      '{10'h06F,6'h10,4'h4,4'hC}};
   // Register reset values, last one an unmapped address
   logic [39:0] rst_tab [11] = '{40'h00_0000006B, 40'h04_00000012, 40'h08_00000001,
      40'h0C_00000012, 40'h10_0000000A, 40'h14_00000000, 40'h18_0000000A,
      40'h1C_000001F4, 40'h20_00000032, 40'h24_000003E8, 40'h3C_00000000};

   // Short millisecond so the minimum-on time stays a few cycles
   motion_io_action_config #(.MS_CYCLES(4)) dut (.*);
   motion_core_model core (.core_clk(core_clk), .rst(rst), .run(run),
      .stop_immediate(stop_immediate), .stop_decel(stop_decel), .core_moving(core_moving));

   // 250 MHz clock
   always #2 core_clk = ~core_clk;

   // Step edges; land just after the edge so outputs have settled
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One-cycle write, then an idle cycle so strobes never repeat in a step
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(1);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      chk("register", rdata, exp);
      tick(1);
   endtask
   task automatic win(input logic [15:0] pe, input logic [11:0] ea, input logic [13:0] f,
                      input logic [13:0] c, input logic [2:0] ex);
      pos_err <= pe;
      elec_angle <= ea;
      fb_wrap_pos <= f;
      cmd_wrap_pos <= c;
      tick(2);
      chk("windows", {in_position, zero_phase_status_output, wrap_zero_output}, ex);
   endtask
   // One-cycle strobe, counting {select, start, learn write} pulses
   task automatic pulse(input logic [1:0] v, input logic [11:0] ex);
      logic [3:0] a, b, c;
      a = 0;
      b = 0;
      c = 0;
      {direct_select_input, learn_strobe} <= v;
      repeat (6)
      begin
         tick(1);
         {direct_select_input, learn_strobe} <= 2'b00;
         a += 4'(op_select);
         b += 4'(op_start);
         c += 4'(learn_type_we);
      end
      chk("strobes", {a, b, c}, ex);
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      tick(20);
      rst <= 1'b0;
      chk("reset outs", {pulse_factor, current_ratio, learn_type, speed_limit_ratio,
          speed_limit_hz}, {5'd1, 10'd1000, 8'd1, 7'd50, 22'd1000});
      foreach (rst_tab[i])
         rreg(rst_tab[i][39:32], rst_tab[i][31:0]);
      foreach (rows[i])
      begin
         wreg(`A_CTRL, 32'(rows[i].ctrl));
         vin <= rows[i].vin;
         tick(2);
         chk("stops", {home_sensor_event, alarm, stop_decel, stop_immediate} & rows[i].m,
             rows[i].ex & rows[i].m);
         chk("current off", current_off, rows[i].vin[1]);
         vin <= 6'h00;
         wreg(`A_ALMCLR, 32'h1);
         tick(2);
      end
      // Window edges, then offset and wrap source
      win(16'd18, 12'd17, 14'd9, 14'd50, 3'b111);
      win(16'd19, 12'd18, 14'd10, 14'd9, 3'b000);
      win(16'hFFEE, 12'd0, 14'd10, 14'd9, 3'b110);
      wreg(`A_INPOS, 32'h0000EE12);
      wreg(`A_CTRL, 32'h16B);
      win(16'hFFDC, 12'd0, 14'd10, 14'd9, 3'b111);
      win(16'd1, 12'd0, 14'd9, 14'd10, 3'b010);
      {pulse_multiply_input, current_limit_input, speed_limit_input} <= 3'b111;
      tick(2);
      chk("limits", {pulse_factor, current_ratio, speed_limit_active, speed_limit_mode,
          speed_limit_ratio}, {5'd10, 10'd500, 2'b10, 7'd50});
      wreg(`A_PLS, 32'd30);
      wreg(`A_PLS, 32'd31);
      wreg(`A_CTRL, 32'h26B);
      tick(1);
      chk("limit value", {pulse_factor, speed_limit_mode, speed_limit_hz},
          {5'd30, 1'b1, 22'd1000});
      {pulse_multiply_input, current_limit_input, speed_limit_input} <= 3'b000;
      pause_input <= 1'b1;
      tick(2);
      chk("pause", {pulse_factor, current_ratio, current_cutback, current_hold},
          {5'd1, 10'd1000, 2'b10});
      wreg(`A_CTRL, 32'h0EB);
      tick(1);
      chk("pause", {current_cutback, current_hold}, 2'b01);
      pause_input <= 1'b0;
      pulse(2'b10, 12'h110);
      wreg(`A_CTRL, 32'h02B);
      pulse(2'b10, 12'h100);
      pulse(2'b01, 12'h001);
      wreg(`A_LEARN, 32'h08);
      pulse(2'b01, 12'h001);
      chk("learn type", learn_type, 8'h08);
      wreg(`A_LEARN, 32'hFF);
      pulse(2'b01, 12'h000);
      // One-cycle move must stretch to two short milliseconds
      wreg(`A_MOVE, 32'd2);
      run <= 1'b1;
      tick(1);
      run <= 1'b0;
      tick(5);
      chk("move held", move_out, 1'b1);
      tick(8);
      chk("move end", move_out, 1'b0);
      // Decelerating halt waits for the core ramp
      run <= 1'b1;
      tick(3);
      vin <= 6'h01;
      tick(2);
      chk("decel", {stop_decel, standstill, core_moving}, 3'b101);
      n = 0;
      while (standstill !== 1'b1 && n < 30)
      begin
         tick(1);
         n++;
      end
      chk("decel end", standstill, 1'b1);
      vin <= 6'h00;
      wreg(`A_CTRL, 32'h028);
      tick(2);
      vin <= 6'h01;
      tick(2);
      chk("immediate", {stop_immediate, standstill, core_moving}, 3'b110);
      vin <= 6'h00;
      run <= 1'b0;
      // Limit alarm latches, raises and masks the interrupt
      wreg(`A_IEN, 32'h1);
      wreg(`A_CTRL, 32'h06B);
      vin <= 6'h10;
      tick(2);
      vin <= 6'h00;
      tick(2);
      chk("alarm", {alarm, irq, motion_enable, stop_immediate}, 4'b1101);
      wreg(`A_ALMCLR, 32'h1);
      wreg(`A_ICLR, 32'h0F);
      tick(1);
      chk("alarm clr", {alarm, irq, motion_enable}, 3'b001);
      wreg(`A_IEN, 32'h0);
      vin <= 6'h20;
      tick(2);
      vin <= 6'h00;
      chk("masked", {alarm, irq}, 2'b10);
      wrap_up();
   end
endmodule
`default_nettype wire
